/* rtl/rtco_cfg.svh */
// Register offsets, field positions, reset values and timing counts for the clock control block.
`ifndef RTCO_CFG_SVH
`define RTCO_CFG_SVH

`define RTCO_ADDR_W          8
`define RTCO_DATA_W          8
`define RTCO_CNT_W           32

`define RTCO_OFF_CONTROL     8'h04
`define RTCO_OFF_OSC_CONTROL 8'h05
`define RTCO_OFF_ALARM0      8'h08
`define RTCO_OFF_ALARM1      8'h09
`define RTCO_OFF_ALARM2      8'h0A
`define RTCO_OFF_ALARM3      8'h0B
`define RTCO_OFF_CAPT0       8'h0C
`define RTCO_OFF_CAPT1       8'h0D
`define RTCO_OFF_CAPT2       8'h0E
`define RTCO_OFF_CAPT3       8'h0F
`define RTCO_OFF_IRQ_STATUS  8'h10
`define RTCO_OFF_IRQ_ENABLE  8'h11
`define RTCO_OFF_IRQ_CLEAR   8'h12

`define RTCO_BIT_OSC_EN      7
`define RTCO_BIT_MCD_EN      6
`define RTCO_BIT_FAIL        5
`define RTCO_BIT_RUN         4
`define RTCO_BIT_ALARM_EN    3
`define RTCO_BIT_ALARM       2
`define RTCO_BIT_SET         1
`define RTCO_BIT_CAPT        0
`define RTCO_BIT_BIAS_X2     5
`define RTCO_BIT_AGC         4

`define RTCO_IRQ_ALARM       0
`define RTCO_IRQ_FAIL        1
`define RTCO_IRQ_W           2

`define RTCO_RESET_BYTE      8'h00
`define RTCO_RESET_CNT       32'h00000000
`define RTCO_ONE_CNT         32'h00000001

// Missing-clock timeout: oscillator ticks must arrive within this many nanoseconds, 5000 core cycles at the 4 ns clock.
`define RTCO_MCD_TIMEOUT_NS  20000
`define RTCO_CLK_PERIOD_NS   4
`define RTCO_MCD_CYCLES      (`RTCO_MCD_TIMEOUT_NS / `RTCO_CLK_PERIOD_NS)
`define RTCO_MCD_W           16
// Count at which a set or capture transfer finishes; the transfer is busy for this many core cycles plus one.
`define RTCO_XFER_CYCLES     4'h3
`define RTCO_XFER_W          4

`endif

/* rtl/rtco_pkg.sv */
// Types shared by the clock control block.
package rtco_pkg;
	typedef struct packed {
		logic osc_enable;
		logic missing_clock_detect_enable;
		logic timer_run;
		logic alarm_enable;
		logic auto_reset;
		logic bias_double;
		logic auto_gain_control;
	} rtco_ctrl_type;

	typedef enum logic [1:0] {
		XFER_IDLE,
		XFER_SET,
		XFER_CAPT
	} rtco_xfer_type;
endpackage

/* rtl/rtco_mcd.sv */
// Missing oscillator tick detector.
`timescale 1ns/10ps
`include "rtco_cfg.svh"
module rtco_mcd
	import rtco_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = `RTCO_MCD_CYCLES
) (
	input  wire logic core_clk,  // Core clock.
	input  wire logic rst,       // Synchronous reset.
	input  wire logic enable,    // Detector armed.
	input  wire logic osc_tick,  // One pulse per oscillator cycle.
	output logic      timeout    // One-cycle pulse on a missing clock.
);
	logic [`RTCO_MCD_W-1:0] cnt_q;

	always_ff @(posedge core_clk) begin
		if (rst || !enable || osc_tick) begin
			cnt_q <= '0;
		end else if (cnt_q != TIMEOUT_CYCLES[`RTCO_MCD_W-1:0]) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			timeout <= 1'b0;
		end else begin
			timeout <= enable && !osc_tick && (cnt_q == TIMEOUT_CYCLES[`RTCO_MCD_W-1:0] - 1'b1);
		end
	end
endmodule

/* rtl/rtco_timer.sv */
// Oscillator-driven timer counter with load and alarm match.
`timescale 1ns/10ps
`include "rtco_cfg.svh"
module rtco_timer
	import rtco_pkg::*;
(
	input  wire logic                   core_clk,    // Core clock.
	input  wire logic                   rst,         // Synchronous reset.
	input  wire logic                   tick,        // Oscillator cycle enable.
	input  wire logic                   run,         // Count on ticks.
	input  wire logic                   load,        // Load the count from load_val.
	input  wire logic [`RTCO_CNT_W-1:0] load_val,    // Value loaded.
	input  wire logic [`RTCO_CNT_W-1:0] alarm_val,   // Alarm compare value.
	input  wire logic                   auto_reset,  // Clear count on alarm match.
	output logic      [`RTCO_CNT_W-1:0] count,       // Current count.
	output logic                        match        // Count reaches alarm on a tick.
);
	assign match = tick && run && (count == alarm_val);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			count <= `RTCO_RESET_CNT;
		end else if (load) begin
			count <= load_val;
		end else if (match && auto_reset) begin
			count <= `RTCO_RESET_CNT;
		end else if (tick && run) begin
			count <= count + `RTCO_ONE_CNT;
		end
	end
endmodule

/* rtl/rtco_ctrl.sv */
// Clock control register, alarm flag, oscillator fail flag, set and capture sequencing.
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`include "rtco_cfg.svh"
module rtco_ctrl
	import rtco_pkg::*;
(
	input  wire logic                     core_clk,     // Core clock, 250 MHz.
	input  wire logic                     rst,          // Synchronous reset, active high.
	input  wire logic [`RTCO_ADDR_W-1:0]  reg_addr,     // Register address.
	input  wire logic [`RTCO_DATA_W-1:0]  reg_wdata,    // Write data.
	input  wire logic                     reg_wr,       // Write strobe.
	input  wire logic                     reg_rd,       // Read strobe.
	output logic      [`RTCO_DATA_W-1:0]  reg_rdata,    // Read data, one cycle after strobe.
	input  wire logic                     osc_tick,     // One pulse per oscillator cycle.
	output logic                          osc_on,       // Oscillator and bias currents on.
	output logic                          bias_x2_on,   // Bias doubling active.
	output logic                          agc_on,       // Gain control active.
	output logic                          alarm_event,  // Alarm flag, one oscillator cycle at most unless the next tick matches again.
	output logic                          irq           // Level interrupt.
);
	rtco_ctrl_type             ctrl_q;
	rtco_xfer_type             xfer_q;
	logic                      fail_q;
	logic                      alarm_q;
	logic [`RTCO_XFER_W-1:0]   xfer_cnt_q;
	logic [`RTCO_CNT_W-1:0]    alarm_val_q;
	logic [`RTCO_CNT_W-1:0]    capt_q;
	logic [`RTCO_IRQ_W-1:0]    irq_stat_q;
	logic [`RTCO_IRQ_W-1:0]    irq_en_q;
	logic [`RTCO_DATA_W-1:0]   rdata_d;
	logic [`RTCO_CNT_W-1:0]    count;
	logic                      match;
	logic                      mcd_timeout;
	logic                      tick;
	logic                      wr_ctrl;
	logic                      wr_osc;
	logic                      xfer_done;
	logic                      load;
	logic [`RTCO_IRQ_W-1:0]    irq_ev;

	assign wr_ctrl = reg_wr && (reg_addr == `RTCO_OFF_CONTROL);
	assign wr_osc  = reg_wr && (reg_addr == `RTCO_OFF_OSC_CONTROL);
	// A stopped oscillator delivers no ticks to the timer.
	assign tick    = osc_tick && ctrl_q.osc_enable;

	// ==========================================================
	// Control fields
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_q <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q.osc_enable                  <= reg_wdata[`RTCO_BIT_OSC_EN];
				ctrl_q.missing_clock_detect_enable <= reg_wdata[`RTCO_BIT_MCD_EN];
				ctrl_q.timer_run                   <= reg_wdata[`RTCO_BIT_RUN];
				ctrl_q.alarm_enable                <= reg_wdata[`RTCO_BIT_ALARM_EN];
				ctrl_q.auto_reset                  <= reg_wdata[`RTCO_BIT_ALARM];
			end
			if (wr_osc) begin
				ctrl_q.bias_double       <= reg_wdata[`RTCO_BIT_BIAS_X2];
				// Gain control is left to software, which must keep it off in self-oscillate mode.
				ctrl_q.auto_gain_control <= reg_wdata[`RTCO_BIT_AGC];
			end
		end
	end

	assign osc_on     = ctrl_q.osc_enable;
	assign bias_x2_on = ctrl_q.bias_double && ctrl_q.osc_enable;
	assign agc_on     = ctrl_q.auto_gain_control && ctrl_q.osc_enable;

	// ==========================================================
	// Alarm compare value
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_alarm
			always_ff @(posedge core_clk) begin
				if (rst) begin
					alarm_val_q[gi*8 +: 8] <= `RTCO_RESET_BYTE;
				end else if (reg_wr && (reg_addr == `RTCO_OFF_ALARM0 + 8'(gi))) begin
					alarm_val_q[gi*8 +: 8] <= reg_wdata;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Fail flag
	rtco_mcd u_mcd (
		.core_clk (core_clk),
		.rst      (rst),
		.enable   (ctrl_q.missing_clock_detect_enable),
		.osc_tick (osc_tick),
		.timeout  (mcd_timeout)
	);

	// The timeout wins over a clearing write in the same cycle so the event is not lost.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fail_q <= 1'b0;
		end else if (mcd_timeout) begin
			fail_q <= 1'b1;
		end else if (wr_ctrl && !reg_wdata[`RTCO_BIT_FAIL]) begin
			fail_q <= 1'b0;
		end
	end

	// ==========================================================
	// Alarm flag
	// The flag lives for one oscillator tick; a match on the next tick re-asserts it.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			alarm_q <= 1'b0;
		end else if (match && ctrl_q.alarm_enable) begin
			alarm_q <= 1'b1;
		end else if (tick || wr_ctrl) begin
			alarm_q <= 1'b0;
		end
	end
	// The write clears it whatever bit 2 holds, unless an enabled match sets it in the same cycle

	assign alarm_event = alarm_q;

	// ==========================================================
	// Set and capture sequencing
	assign xfer_done = (xfer_q != XFER_IDLE) && (xfer_cnt_q == `RTCO_XFER_CYCLES);
	assign load      = xfer_done && (xfer_q == XFER_SET);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			xfer_q <= XFER_IDLE;
		end else begin
			unique case (xfer_q)
				XFER_IDLE: begin
					if (wr_ctrl && reg_wdata[`RTCO_BIT_SET]) begin
						xfer_q <= XFER_SET;
					end else if (wr_ctrl && reg_wdata[`RTCO_BIT_CAPT]) begin
						xfer_q <= XFER_CAPT;
					end
				end
				XFER_SET, XFER_CAPT: begin
					if (xfer_done) begin
						xfer_q <= XFER_IDLE;
					end
				end
				default: begin
					xfer_q <= XFER_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || xfer_q == XFER_IDLE) begin
			xfer_cnt_q <= '0;
		end else begin
			xfer_cnt_q <= xfer_cnt_q + 1'b1;
		end
	end

	// Software fills the holding bytes before a set; a finishing capture wins over a write in the same cycle.
	generate
		for (gi = 0; gi < 4; gi++) begin : g_capt
			always_ff @(posedge core_clk) begin
				if (rst) begin
					capt_q[gi*8 +: 8] <= `RTCO_RESET_BYTE;
				end else if (xfer_done && xfer_q == XFER_CAPT) begin
					capt_q[gi*8 +: 8] <= count[gi*8 +: 8];
				end else if (reg_wr && (reg_addr == `RTCO_OFF_CAPT0 + 8'(gi))) begin
					capt_q[gi*8 +: 8] <= reg_wdata;
				end
			end
		end
	endgenerate

	// The set loads the capture holding register into the timer.
	rtco_timer u_timer (
		.core_clk   (core_clk),
		.rst        (rst),
		.tick       (tick),
		.run        (ctrl_q.timer_run),
		.load       (load),
		.load_val   (capt_q),
		.alarm_val  (alarm_val_q),
		.auto_reset (ctrl_q.auto_reset),
		.count      (count),
		.match      (match)
	);

	// ==========================================================
	// Interrupts
	assign irq_ev = {mcd_timeout, match && ctrl_q.alarm_enable};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_stat_q <= '0;
		end else begin
			for (int i = 0; i < `RTCO_IRQ_W; i++) begin
				if (irq_ev[i]) begin
					irq_stat_q[i] <= 1'b1;
				end else if (reg_wr && reg_addr == `RTCO_OFF_IRQ_CLEAR && reg_wdata[i]) begin
					irq_stat_q[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_en_q <= '0;
		end else if (reg_wr && reg_addr == `RTCO_OFF_IRQ_ENABLE) begin
			irq_en_q <= reg_wdata[`RTCO_IRQ_W-1:0];
		end
	end

	assign irq = |(irq_stat_q & irq_en_q);

	// ==========================================================
	// Read path
	always_comb begin
		rdata_d = '0;
		unique case (reg_addr)
			`RTCO_OFF_CONTROL: begin
				rdata_d[`RTCO_BIT_OSC_EN]   = ctrl_q.osc_enable;
				rdata_d[`RTCO_BIT_MCD_EN]   = ctrl_q.missing_clock_detect_enable;
				rdata_d[`RTCO_BIT_FAIL]     = fail_q && ctrl_q.osc_enable;
				rdata_d[`RTCO_BIT_RUN]      = ctrl_q.timer_run;
				rdata_d[`RTCO_BIT_ALARM_EN] = ctrl_q.alarm_enable;
				rdata_d[`RTCO_BIT_ALARM]    = alarm_q;
				rdata_d[`RTCO_BIT_SET]      = (xfer_q == XFER_SET);
				rdata_d[`RTCO_BIT_CAPT]     = (xfer_q == XFER_CAPT);
			end
			`RTCO_OFF_OSC_CONTROL: begin
				rdata_d[`RTCO_BIT_BIAS_X2] = ctrl_q.bias_double;
				rdata_d[`RTCO_BIT_AGC]     = ctrl_q.auto_gain_control;
			end
			`RTCO_OFF_ALARM0: rdata_d = alarm_val_q[7:0];
			`RTCO_OFF_ALARM1: rdata_d = alarm_val_q[15:8];
			`RTCO_OFF_ALARM2: rdata_d = alarm_val_q[23:16];
			`RTCO_OFF_ALARM3: rdata_d = alarm_val_q[31:24];
			`RTCO_OFF_CAPT0:  rdata_d = capt_q[7:0];
			`RTCO_OFF_CAPT1:  rdata_d = capt_q[15:8];
			`RTCO_OFF_CAPT2:  rdata_d = capt_q[23:16];
			`RTCO_OFF_CAPT3:  rdata_d = capt_q[31:24];
			`RTCO_OFF_IRQ_STATUS: rdata_d[`RTCO_IRQ_W-1:0] = irq_stat_q;
			`RTCO_OFF_IRQ_ENABLE: rdata_d[`RTCO_IRQ_W-1:0] = irq_en_q;
			default: rdata_d = '0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= '0;
		end
	end

	// ==========================================================
	// Assertions
	property p_osc_follows_write;
		@(posedge core_clk) disable iff (rst)
		wr_ctrl |=> (osc_on == $past(reg_wdata[`RTCO_BIT_OSC_EN]));
	endproperty
	a_osc_follows_write: assert property (p_osc_follows_write) else $error("osc_on does not follow write");

	property p_fail_set;
		@(posedge core_clk) disable iff (rst)
		mcd_timeout |=> fail_q;
	endproperty
	a_fail_set: assert property (p_fail_set) else $error("fail flag not set on timeout");

	property p_fail_sticky;
		@(posedge core_clk) disable iff (rst)
		fail_q && !wr_ctrl |=> fail_q;
	endproperty
	a_fail_sticky: assert property (p_fail_sticky) else $error("fail flag cleared without a write");

	property p_hold_when_stopped;
		@(posedge core_clk) disable iff (rst)
		!ctrl_q.timer_run && !load |=> count == $past(count);
	endproperty
	a_hold_when_stopped: assert property (p_hold_when_stopped) else $error("count moved while stopped");

	property p_write_clears_alarm;
		@(posedge core_clk) disable iff (rst)
		wr_ctrl && !(match && ctrl_q.alarm_enable) |=> !alarm_q;
	endproperty
	a_write_clears_alarm: assert property (p_write_clears_alarm) else $error("write did not clear alarm");

	property p_alarm_short;
		@(posedge core_clk) disable iff (rst)
		alarm_q && tick && !match |=> !alarm_q;
	endproperty
	a_alarm_short: assert property (p_alarm_short) else $error("alarm flag outlived a tick");

	sequence s_set_start;
		wr_ctrl && reg_wdata[`RTCO_BIT_SET] && xfer_q == XFER_IDLE;
	endsequence
	sequence s_set_busy;
		(xfer_q == XFER_SET) [*4];
	endsequence
	property p_set_seq;
		@(posedge core_clk) disable iff (rst)
		s_set_start |=> s_set_busy ##1 (xfer_q == XFER_IDLE);
	endproperty
	a_set_seq: assert property (p_set_seq) else $error("set sequence wrong length");

	property p_capt_done;
		@(posedge core_clk) disable iff (rst)
		wr_ctrl && reg_wdata[`RTCO_BIT_CAPT] && !reg_wdata[`RTCO_BIT_SET] && xfer_q == XFER_IDLE
		|=> (xfer_q == XFER_CAPT) ##[1:4] (xfer_q == XFER_IDLE);
	endproperty
	a_capt_done: assert property (p_capt_done) else $error("capture did not complete");

	property p_no_restart;
		@(posedge core_clk) disable iff (rst)
		xfer_q == XFER_SET && !xfer_done |=> xfer_q == XFER_SET && xfer_cnt_q == $past(xfer_cnt_q) + 1'b1;
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("busy transfer restarted");

	property p_alarm_read;
		@(posedge core_clk) disable iff (rst)
		reg_rd && reg_addr == `RTCO_OFF_CONTROL |=> reg_rdata[`RTCO_BIT_ALARM] == $past(alarm_q);
	endproperty
	a_alarm_read: assert property (p_alarm_read) else $error("alarm flag read back wrong");

	property p_bias_follows;
		@(posedge core_clk) disable iff (rst)
		wr_osc |=> bias_x2_on == ($past(reg_wdata[`RTCO_BIT_BIAS_X2]) && osc_on);
	endproperty
	a_bias_follows: assert property (p_bias_follows) else $error("bias doubling does not follow write");
endmodule

/* verification/rtco_ctrl_test.sv */
// Self-checking testbench for the clock control block.
`timescale 1ns/10ps
`include "rtco_cfg.svh"
module rtco_ctrl_test;
	localparam logic [7:0] ctl_a = `RTCO_OFF_CONTROL;
	localparam logic [7:0] xcn_a = `RTCO_OFF_OSC_CONTROL;
	localparam logic [7:0] alm_a = `RTCO_OFF_ALARM0;
	localparam logic [7:0] cap_a = `RTCO_OFF_CAPT0;
	localparam logic [7:0] sts_a = `RTCO_OFF_IRQ_STATUS;
	localparam logic [7:0] ena_a = `RTCO_OFF_IRQ_ENABLE;
	localparam logic [7:0] clr_a = `RTCO_OFF_IRQ_CLEAR;

	logic                    core_clk;
	logic                    rst;
	logic [`RTCO_ADDR_W-1:0] reg_addr;
	logic [`RTCO_DATA_W-1:0] reg_wdata;
	logic                    reg_wr;
	logic                    reg_rd;
	logic [`RTCO_DATA_W-1:0] reg_rdata;
	logic                    osc_tick;
	logic                    osc_on;
	logic                    bias_x2_on;
	logic                    agc_on;
	logic                    alarm_event;
	logic                    irq;
	integer                  fails;
	integer                  check_count;
	integer                  seed;
	integer                  k;
	logic [31:0]             load_a;
	logic [31:0]             load_b;
	logic [31:0]             got;
	logic [7:0]              rv;

	rtco_ctrl dut_u (
		.core_clk    (core_clk),
		.rst         (rst),
		.reg_addr    (reg_addr),
		.reg_wdata   (reg_wdata),
		.reg_wr      (reg_wr),
		.reg_rd      (reg_rd),
		.reg_rdata   (reg_rdata),
		.osc_tick    (osc_tick),
		.osc_on      (osc_on),
		.bias_x2_on  (bias_x2_on),
		.agc_on      (agc_on),
		.alarm_event (alarm_event),
		.irq         (irq)
	);

	// ==========================================================
	// Clock, checks and bus tasks
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic wr32(input logic [7:0] a, input logic [31:0] v);
		for (int i = 0; i < 4; i++) begin
			wr(a + 8'(i), v[8*i +: 8]);
		end
	endtask

	task automatic rd32(input logic [7:0] a, output logic [31:0] v);
		logic [7:0] b;
		for (int i = 0; i < 4; i++) begin
			rd(a + 8'(i), b);
			v[8*i +: 8] = b;
		end
	endtask

	task automatic tick;
		@(posedge core_clk);
		osc_tick <= 1'b1;
		@(posedge core_clk);
		osc_tick <= 1'b0;
		#1;
	endtask

	task automatic settle;
		@(posedge core_clk);
		#1;
	endtask

	// Capture the count and return it; the request bit must have cleared by then.
	task automatic capture(input logic [7:0] c, output logic [31:0] v);
		logic [7:0] b;
		wr(ctl_a, c | 8'h01);
		repeat (6) @(posedge core_clk);
		rd(ctl_a, b);
		chk(b[0], 1'b0);
		rd32(cap_a, v);
	endtask

	// ==========================================================
	// Watchdog: the sequence needs about 10400 cycles.
	initial begin
		repeat (40000) @(posedge core_clk);
		fails++;
		give_verdict;
	end

	// ==========================================================
	// Main sequence
	initial begin
		seed = 32'hF0C9FDC0;
		fails = 0;
		check_count = 0;
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		osc_tick = 1'b0;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		settle;
		chk({osc_on, bias_x2_on, agc_on, alarm_event, irq}, 5'h00);
		rd(ctl_a, rv);
		chk(rv, 8'h00);
		rd(8'h3F, rv);
		chk(rv, 8'h00);
		// Gain control stays off here since the oscillator mode is not known.
		wr(ctl_a, 8'h80);
		wr(xcn_a, 8'h20);
		settle;
		chk({osc_on, bias_x2_on, agc_on}, 3'b110);
		rd(xcn_a, rv);
		chk(rv, 8'h20);
		wr(ctl_a, 8'h00);
		settle;
		chk({osc_on, bias_x2_on}, 2'b00);
		wr(xcn_a, 8'h00);

		load_a = $random(seed);
		load_a[31:28] = 4'h0;
		load_b = $random(seed);
		load_b[31:28] = 4'h0;
		wr32(cap_a, load_a);
		wr(ctl_a, 8'h82);
		// A second start while busy must not stretch the transfer.
		wr(ctl_a, 8'h82);
		rd(ctl_a, rv);
		chk(rv[1], 1'b1);
		rd(ctl_a, rv);
		chk(rv[1], 1'b0);
		wr32(cap_a, load_b);
		capture(8'h80, got);
		chk(got, load_a);
		wr(ctl_a, 8'h90);
		repeat (5) tick;
		wr(ctl_a, 8'h80);
		repeat (3) tick;
		capture(8'h80, got);
		chk(got, load_a + 32'd5);

		wr32(alm_a, load_a + 32'd7);
		wr(ena_a, 8'h01);
		wr(ctl_a, 8'h98);
		k = 0;
		while (alarm_event !== 1'b1 && k < 10) begin
			tick;
			k++;
		end
		chk(k, 32'd3);
		rd(ctl_a, rv);
		chk(rv, 8'h9C);
		chk(irq, 1'b1);
		wr(ctl_a, 8'h9C);
		settle;
		chk(alarm_event, 1'b0);
		rd(ctl_a, rv);
		chk(rv, 8'h98);

		wr(ctl_a, 8'h8C);
		wr32(cap_a, load_b);
		wr(ctl_a, 8'h8E);
		repeat (6) @(posedge core_clk);
		wr32(alm_a, load_b + 32'd1);
		wr(ctl_a, 8'h9C);
		k = 0;
		while (alarm_event !== 1'b1 && k < 10) begin
			tick;
			k++;
		end
		chk(k, 32'd2);
		tick;
		chk(alarm_event, 1'b0);
		wr(ctl_a, 8'h8C);
		capture(8'h8C, got);
		chk(got, 32'd1);

		rd(sts_a, rv);
		chk(rv[`RTCO_IRQ_ALARM], 1'b1);
		wr(ena_a, 8'h00);
		settle;
		chk(irq, 1'b0);
		wr(clr_a, 8'h01);
		rd(sts_a, rv);
		chk(rv, 8'h00);
		wr(ena_a, 8'h03);

		wr(ctl_a, 8'h80);
		repeat (5100) @(posedge core_clk);
		rd(ctl_a, rv);
		chk(rv, 8'h80);
		wr(ctl_a, 8'hC0);
		repeat (5100) @(posedge core_clk);
		rd(ctl_a, rv);
		chk(rv, 8'hE0);
		chk(irq, 1'b1);
		wr(ctl_a, 8'hA0);
		rd(ctl_a, rv);
		chk(rv, 8'hA0);
		wr(ctl_a, 8'h80);
		rd(ctl_a, rv);
		chk(rv, 8'h80);
		wr(clr_a, 8'h02);
		settle;
		chk(irq, 1'b0);
		give_verdict;
	end
endmodule
